// ===== bawf_adder.sv
// Eight-bit adder split at bits 3 and 6 so the flag carries are visible
`timescale 1ns/10ps
module bawf_adder (
  bawf_alu_if.alu bus
);
  logic [4:0] low_sum;
  logic [3:0] mid_sum;
  logic [1:0] top_sum;

  assign low_sum = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.cin};
  assign mid_sum = {1'b0, bus.a[6:4]} + {1'b0, bus.b[6:4]} + {3'h0, low_sum[4]};
  assign top_sum = {1'b0, bus.a[7]} + {1'b0, bus.b[7]} + {1'b0, mid_sum[3]};
  assign bus.sum = {top_sum[0], mid_sum[2:0], low_sum[3:0]};
  assign bus.carry_out = top_sum[1];
  assign bus.half_carry_out = low_sum[4];
  // Overflow is the disagreement of the carries into and out of bit 7
  assign bus.signed_wrap_out = mid_sum[3] ^ top_sum[1];
endmodule // bawf_adder

// ===== bawf_alu_if.sv
// Operand and result bundle between the datapath and its adder
`timescale 1ns/10ps
interface bawf_alu_if;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic [7:0] sum;
  logic carry_out;
  logic half_carry_out;
  logic signed_wrap_out;
  modport alu (
    input a,
    input b,
    input cin,
    output sum,
    output carry_out,
    output half_carry_out,
    output signed_wrap_out
  );
  modport core (
    output a,
    output b,
    output cin,
    input sum,
    input carry_out,
    input half_carry_out,
    input signed_wrap_out
  );
endinterface // bawf_alu_if

// ===== bawf_decode.sv
// Opcode decoder for the add and add-with-carry forms
`timescale 1ns/10ps
module bawf_decode #(
  parameter logic [3:0] SUM_WITH_CARRY_IN_HI = 4'h3
) (
  input wire logic [7:0] i_opcode,
  output bawf_pkg::bawf_src_t o_src,
  output logic o_with_carry,
  output logic o_legal,
  output logic [2:0] o_sel
);
  import bawf_pkg::*;
  logic is_add;
  logic is_sum_with_carry_in;

  assign is_add = i_opcode[7:4] == ADD_HI;
  assign is_sum_with_carry_in = i_opcode[7:4] == SUM_WITH_CARRY_IN_HI;
  assign o_with_carry = is_sum_with_carry_in;
  assign o_sel = i_opcode[2:0];

  always_comb begin
    o_src = SRC_NONE;
    if (is_add || is_sum_with_carry_in) begin
      if (i_opcode[3:0] == LO_IMM) begin
        o_src = SRC_IMM;
      end else if (i_opcode[3:0] == LO_DIRECT) begin
        o_src = SRC_DIRECT;
      end else if (i_opcode[3:1] == LO_INDIRECT) begin
        o_src = SRC_INDIRECT;
      end else if (is_sum_with_carry_in && i_opcode[3]) begin
        // Register form is decoded for add-with-carry only
        o_src = SRC_REG;
      end
    end
  end

  assign o_legal = o_src != SRC_NONE;
endmodule // bawf_decode

// ===== bawf_host_model.sv
// Bus master standing in for the fetch and operand access side
`timescale 1ns/10ps
module bawf_host_model (
  input wire logic i_clk,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr
);
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end
  // Idle edge first, so a back-to-back call never assigns psel twice at one edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    // Read just after the rising edge, before that edge's own updates land
    do @(posedge i_clk); while (i_pready !== 1'b1);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // Released lines show junk so a late sample by the slave is caught
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask
endmodule // bawf_host_model

// ===== bawf_pkg.sv
// Shared constants and types for the byte add datapath
package bawf_pkg;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_ACC = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_INSTR = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MEM = 8'h40;
  // Field positions
  localparam int FLAG_CARRY_BIT = 0;
  localparam int FLAG_HALF_BIT = 1;
  localparam int FLAG_WRAP_BIT = 2;
  localparam int INSTR_OP_LSB = 0;
  localparam int INSTR_ARG_LSB = 8;
  localparam int INSTR_ILLEGAL_BIT = 16;
  // Reset values
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic RST_FLAG = 1'b0;
  localparam logic [7:0] RST_OPCODE = 8'h00;
  localparam logic [7:0] RST_ARG = 8'h00;
  localparam logic [7:0] RST_MEM = 8'h00;
  // Opcode fields
  localparam logic [3:0] ADD_HI = 4'h2;
  localparam logic [3:0] LO_IMM = 4'h4;
  localparam logic [3:0] LO_DIRECT = 4'h5;
  localparam logic [2:0] LO_INDIRECT = 3'h3;
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_IMM = 3'b001,
    SRC_DIRECT = 3'b010,
    SRC_INDIRECT = 3'b011,
    SRC_REG = 3'b100
  } bawf_src_t;
endpackage

// ===== bawf_top.sv
// Byte add datapath with flags, reached over APB
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps
// What this block does
// - The direct add takes its second byte as a data address and adds that byte to ACC.
// - The indirect add adds the byte addressed by pointer register 0 or 1 to ACC.
// - The immediate add adds its literal second byte to ACC and keeps the sum in ACC.
// - Add-with-carry sums source byte, carry flag and ACC and keeps 8 bits in ACC.
// - Carry is set on a carry out of bit 7 and half carry on one out of bit 3, else cleared.
// - The signed wrap flag is set when exactly one of the carries out of bits 6 and 7 occurs.
// - Add-with-carry takes its source as working register, direct, pointer or immediate.
module bawf_top #(
  parameter int DEPTH = 16,
  parameter logic [3:0] SUM_WITH_CARRY_IN_HI = 4'h3
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [bawf_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [7:0] o_acc,
  output logic o_carry_flag,
  output logic o_half_carry_flag,
  output logic o_signed_wrap_flag
);
  import bawf_pkg::*;
  localparam int IW = $clog2(DEPTH);

  logic [7:0] acc_reg;
  logic carry_reg;
  logic half_reg;
  logic wrap_reg;
  logic [7:0] opcode_reg;
  logic [7:0] arg_reg;
  logic exec_reg;
  logic illegal_reg;
  logic wait_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_next;
  logic [7:0] mem_reg [DEPTH];

  logic access;
  logic wr_fire;
  logic sel_acc;
  logic sel_flags;
  logic sel_instr;
  logic [ADDR_W-1:0] mem_rel;
  logic mem_hit;
  logic [IW-1:0] mem_idx;
  logic hit;

  bawf_src_t src;
  logic with_carry;
  logic legal;
  logic [2:0] sel;
  logic [7:0] operand;
  logic exec_fire;

  // APB slave: one wait state so a read right after an instruction sees its result
  assign access = i_psel & i_penable;
  assign o_pready = access & wait_reg;
  assign wr_fire = o_pready & i_pwrite;
  assign sel_acc = i_paddr == OFF_ACC;
  assign sel_flags = i_paddr == OFF_FLAGS;
  assign sel_instr = i_paddr == OFF_INSTR;
  assign mem_rel = i_paddr - OFF_MEM;
  assign mem_hit = (i_paddr >= OFF_MEM) && (i_paddr[1:0] == 2'h0) &&
                   (mem_rel[ADDR_W-1:2] < (ADDR_W-2)'(DEPTH));
  assign mem_idx = mem_rel[IW+1:2];
  assign hit = sel_acc | sel_flags | sel_instr | mem_hit;
  assign o_pslverr = o_pready & ~hit;
  assign o_prdata = prdata_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= access & ~wait_reg;
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    if (sel_acc) begin
      rd_next[7:0] = acc_reg;
    end else if (sel_flags) begin
      rd_next[FLAG_CARRY_BIT] = carry_reg;
      rd_next[FLAG_HALF_BIT] = half_reg;
      rd_next[FLAG_WRAP_BIT] = wrap_reg;
    end else if (sel_instr) begin
      rd_next[INSTR_OP_LSB +: 8] = opcode_reg;
      rd_next[INSTR_ARG_LSB +: 8] = arg_reg;
      rd_next[INSTR_ILLEGAL_BIT] = illegal_reg;
    end else if (mem_hit) begin
      rd_next[7:0] = mem_reg[mem_idx];
    end
  end

  // Captured in the wait cycle, after any pending instruction has retired
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (access && !wait_reg && !i_pwrite) begin
      prdata_reg <= rd_next;
    end
  end

  // Instruction register: a write issues it for execution on the next edge
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      opcode_reg <= RST_OPCODE;
      arg_reg <= RST_ARG;
      exec_reg <= 1'b0;
    end else begin
      exec_reg <= wr_fire & sel_instr;
      if (wr_fire && sel_instr) begin
        opcode_reg <= i_pwdata[INSTR_OP_LSB +: 8];
        arg_reg <= i_pwdata[INSTR_ARG_LSB +: 8];
      end
    end
  end

  bawf_decode #(
    .SUM_WITH_CARRY_IN_HI(SUM_WITH_CARRY_IN_HI)
  ) u_decode (
    .i_opcode(opcode_reg),
    .o_src(src),
    .o_with_carry(with_carry),
    .o_legal(legal),
    .o_sel(sel)
  );

  assign exec_fire = exec_reg & legal;

  // Operand fetch; pointer registers are data bytes 0 and 1, working registers 0 to 7
  always_comb begin
    unique case (src)
      SRC_IMM: operand = arg_reg;
      SRC_DIRECT: operand = mem_reg[arg_reg[IW-1:0]];
      SRC_INDIRECT: operand = mem_reg[mem_reg[IW'(sel[0])][IW-1:0]];
      SRC_REG: operand = mem_reg[IW'(sel)];
      default: operand = 8'h00;
    endcase
  end

  bawf_alu_if alu ();
  assign alu.a = acc_reg;
  assign alu.b = operand;
  // Plain add forces the carry input low
  assign alu.cin = with_carry & carry_reg;

  bawf_adder u_adder (
    .bus(alu.alu)
  );

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_reg <= RST_ACC;
    end else if (exec_fire) begin
      acc_reg <= alu.sum;
    end else if (wr_fire && sel_acc) begin
      acc_reg <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      carry_reg <= RST_FLAG;
      half_reg <= RST_FLAG;
      wrap_reg <= RST_FLAG;
    end else if (exec_fire) begin
      carry_reg <= alu.carry_out;
      half_reg <= alu.half_carry_out;
      wrap_reg <= alu.signed_wrap_out;
    end else if (wr_fire && sel_flags) begin
      carry_reg <= i_pwdata[FLAG_CARRY_BIT];
      half_reg <= i_pwdata[FLAG_HALF_BIT];
      wrap_reg <= i_pwdata[FLAG_WRAP_BIT];
    end
  end

  // An unknown opcode leaves accumulator and flags untouched and is only reported
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      illegal_reg <= 1'b0;
    end else if (exec_reg) begin
      illegal_reg <= ~legal;
    end
  end

  // Data bytes: working registers at the bottom, the rest reachable by direct address
  for (genvar g = 0; g < DEPTH; g++) begin : g_mem
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        mem_reg[g] <= RST_MEM;
      end else if (wr_fire && mem_hit && mem_idx == IW'(g)) begin
        mem_reg[g] <= i_pwdata[7:0];
      end
    end
  end

  assign o_acc = acc_reg;
  assign o_carry_flag = carry_reg;
  assign o_half_carry_flag = half_reg;
  assign o_signed_wrap_flag = wrap_reg;

  // Reference values built apart from the adder, for the checks below
  logic [8:0] ref_sum;
  logic [4:0] ref_low;
  logic ref_wrap;
  logic ref_cin;
  assign ref_cin = with_carry ? carry_reg : 1'b0;
  assign ref_sum = {1'b0, acc_reg} + {1'b0, operand} + {8'h00, ref_cin};
  assign ref_low = {1'b0, acc_reg[3:0]} + {1'b0, operand[3:0]} + {4'h0, ref_cin};
  assign ref_wrap = (acc_reg[7] == operand[7]) && (ref_sum[7] != acc_reg[7]);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  a_direct_add_result: assert property (
    exec_reg && src == SRC_DIRECT && !with_carry
      |=> acc_reg == $past(ref_sum[7:0]))
    else $error("direct add result wrong");

  a_indirect_add_result: assert property (
    exec_reg && src == SRC_INDIRECT && !with_carry
      |=> acc_reg == $past(ref_sum[7:0]))
    else $error("indirect add result wrong");

  a_immediate_add_result: assert property (
    exec_reg && src == SRC_IMM && !with_carry
      |=> acc_reg == ($past(acc_reg) + $past(arg_reg)))
    else $error("immediate add result wrong");

  a_carry_add_result: assert property (
    exec_fire && with_carry
      |=> acc_reg == ($past(acc_reg) + $past(operand) + {7'h00, $past(carry_reg)}))
    else $error("add with carry result wrong");

  a_carry_flag_value: assert property (
    exec_fire |=> carry_reg == $past(ref_sum[8]))
    else $error("carry flag wrong after add");

  a_half_flag_value: assert property (
    exec_fire |=> half_reg == $past(ref_low[4]))
    else $error("half carry flag wrong after add");

  a_wrap_flag_value: assert property (
    exec_fire |=> wrap_reg == $past(ref_wrap))
    else $error("signed wrap flag wrong after add");

  a_reg_source_fetch: assert property (
    exec_reg && opcode_reg[7:4] == SUM_WITH_CARRY_IN_HI && opcode_reg[3]
      |-> src == SRC_REG && operand == mem_reg[IW'(opcode_reg[2:0])])
    else $error("register source not fetched");

  a_plain_zero_cin: assert property (
    exec_reg && opcode_reg[7:4] == ADD_HI |-> !alu.cin && !with_carry)
    else $error("plain add used a carry input");

  a_illegal_no_change: assert property (
    exec_reg && !legal |=> $stable(acc_reg) && $stable(carry_reg) && illegal_reg)
    else $error("illegal opcode changed state");

  a_read_wait_state: assert property (
    access && !wait_reg |-> !o_pready ##1 (!access || o_pready))
    else $error("apb answer timing wrong");

  a_error_needs_ready: assert property (
    o_pslverr |-> o_pready)
    else $error("slave error raised without ready");

  a_ready_one_cycle: assert property (
    o_pready |=> !o_pready)
    else $error("ready stood for more than one cycle");

  a_stray_write_ignored: assert property (
    wr_fire && !hit |=> $stable(acc_reg) && $stable(carry_reg) && $stable(wrap_reg))
    else $error("unmapped write changed state");

  a_adder_matches_ref: assert property (
    exec_fire |-> alu.sum == ref_sum[7:0] && alu.carry_out == ref_sum[8] &&
      alu.half_carry_out == ref_low[4])
    else $error("adder disagrees with reference sum");

  a_flags_hold_idle: assert property (
    !exec_fire && !(wr_fire && sel_flags)
      |=> $stable(carry_reg) && $stable(half_reg) && $stable(wrap_reg))
    else $error("flags changed without an add");

  a_acc_hold_idle: assert property (
    !exec_fire && !(wr_fire && sel_acc) |=> $stable(acc_reg))
    else $error("accumulator changed without an add");

  c_sum_with_carry_in_register: cover property (exec_fire && src == SRC_REG && carry_reg);
  c_signed_wrap: cover property (exec_fire ##1 wrap_reg && !carry_reg);
  c_indirect_add: cover property (exec_fire && src == SRC_INDIRECT);
  c_unmapped_access: cover property (o_pslverr);
  c_half_carry: cover property (exec_fire && alu.half_carry_out);
endmodule // bawf_top

// ===== tb_top.sv
// Self-checking bench for the byte add datapath
`timescale 1ns/10ps
module tb_top;
  import bawf_pkg::*;
  localparam logic [3:0] SUM_WITH_CARRY_IN_OP = 4'h3;
  logic i_clk, i_resetn, psel, penable, pwrite, pready, pslverr, cy, hc, sw;
  logic [7:0] paddr, acc, m_acc;
  logic [31:0] pwdata, prdata;
  logic [2:0] m_fl;
  logic [7:0] mem [16];
  int miscompares = 0;
  int tests_run = 0;
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  bawf_top #(.DEPTH(16), .SUM_WITH_CARRY_IN_HI(SUM_WITH_CARRY_IN_OP)) dut_u (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_acc(acc), .o_carry_flag(cy), .o_half_carry_flag(hc), .o_signed_wrap_flag(sw));
  bawf_host_model host_u (.i_clk(i_clk), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
    .i_pready(pready), .i_pslverr(pslverr));
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    logic [31:0] q;
    logic e;
    host_u.xfer(1'b1, a, d, q, e);
    check({31'h0, e}, {31'h0, err}, "write response");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic err, input string s);
    logic [31:0] q;
    logic e;
    host_u.xfer(1'b0, a, 32'h0, q, e);
    check({31'h0, e}, {31'h0, err}, "read response");
    check(q, x, s);
  endtask
  // Returns wrap, half, carry and the 8-bit sum
  function automatic logic [10:0] add_ref(input logic [7:0] a, b, input logic c);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] l;
    s = 9'(a) + 9'(b) + 9'(c);
    h = 5'(a[3:0]) + 5'(b[3:0]) + 5'(c);
    l = 8'(a[6:0]) + 8'(b[6:0]) + 8'(c);
    return {s[8] ^ l[7], h[4], s[8], s[7:0]};
  endfunction
  task automatic set(input logic [7:0] a, input logic [2:0] f);
    wr(OFF_ACC, {24'h0, a}, 1'b0);
    wr(OFF_FLAGS, {29'h0, f}, 1'b0);
    m_acc = a;
    m_fl = f;
  endtask
  task automatic issue(input logic [7:0] op, input logic [7:0] arg);
    logic [7:0] src;
    logic [10:0] r;
    logic ok;
    ok = (op[7:4] == 4'h2 && op[3:2] == 2'b01) || (op[7:4] == SUM_WITH_CARRY_IN_OP && op[3:2] != 2'b00);
    if (op[3]) src = mem[op[2:0]];
    else if (op[1]) src = mem[mem[op[0]][3:0]];
    else if (op[0]) src = mem[arg[3:0]];
    else src = arg;
    r = add_ref(m_acc, src, op[4] & m_fl[0]);
    wr(OFF_INSTR, {16'h0, arg, op}, 1'b0);
    if (ok) begin
      m_acc = r[7:0];
      m_fl = r[10:8];
    end
    rd(OFF_ACC, {24'h0, m_acc}, 1'b0, "acc");
    rd(OFF_FLAGS, {29'h0, m_fl}, 1'b0, "flags");
    rd(OFF_INSTR, {15'h0, !ok, arg, op}, 1'b0, "instr");
    check({21'h0, sw, hc, cy, acc}, {21'h0, m_fl, m_acc}, "ports");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    // About 1000 cycles of traffic are expected
    #200000;
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    i_resetn = 1'b0;
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(OFF_ACC, 32'h0, 1'b0, "acc after reset");
    rd(OFF_FLAGS, 32'h0, 1'b0, "flags after reset");
    rd(8'h0c, 32'h0, 1'b1, "unmapped");
    rd(8'h01, 32'h0, 1'b1, "unaligned");
    wr(8'h3c, 32'h55, 1'b1);
    for (int n = 0; n < 16; n++) begin
      mem[n] = 8'h05 + 8'(n) * 8'h37;
      wr(OFF_MEM + 8'(4 * n), {24'h0, mem[n]}, 1'b0);
    end
    rd(OFF_MEM + 8'h3c, {24'h0, mem[15]}, 1'b0, "data byte");
    // Carry flag both set and clear on both plain and carry forms, all sources
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 16; i++) begin
        set(8'h8f - 8'(i) * 8'h13 + 8'(p) * 8'h71, 3'(i + p));
        issue(i < 4 ? 8'h24 + 8'(i) : {SUM_WITH_CARRY_IN_OP, 4'(i)}, 8'h7e + 8'(i) * 8'h29);
      end
    end
    wr(OFF_MEM, 32'haa, 1'b0);
    mem[0] = 8'haa;
    set(8'hc3, 3'h1);
    issue({SUM_WITH_CARRY_IN_OP, 4'h8}, 8'h00);
    set(8'h5a, 3'h7);
    issue(8'h28, 8'h11);
    issue({SUM_WITH_CARRY_IN_OP, 4'h3}, 8'h22);
    issue(8'h24, 8'hff);
    // Reset in mid-run clears accumulator, flags and data bytes
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(OFF_ACC, 32'h0, 1'b0, "acc after second reset");
    rd(OFF_FLAGS, 32'h0, 1'b0, "flags after second reset");
    rd(OFF_MEM, 32'h0, 1'b0, "data byte after second reset");
    conclude();
  end
endmodule // tb_top
